// >>> core/fsh_pkg.sv
package fsh_pkg;
   // ----------------------------------------------------------------
   // Bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   // ----------------------------------------------------------------
   // Flash command codes and unlock addresses
   // ----------------------------------------------------------------
   localparam logic [21:0] UNLOCK_ADDR1  = 22'h000555;
   localparam logic [21:0] UNLOCK_ADDR2  = 22'h0002aa;
   localparam logic [15:0] UNLOCK_DATA1  = 16'h00aa;
   localparam logic [15:0] UNLOCK_DATA2  = 16'h0055;
   localparam logic [15:0] CMD_SOFT_RESET = 16'h00f0;
   localparam logic [15:0] CMD_ID_READ    = 16'h0090;
   // ----------------------------------------------------------------
   // Protection check
   // ----------------------------------------------------------------
   localparam logic [2:0]  PROT_ID_PATTERN = 3'h2;
   localparam logic [15:0] PROT_YES        = 16'h0001;
   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int MAIN_TOGGLE_BIT  = 6;
   localparam int ERASE_TOGGLE_BIT = 2;
   // ----------------------------------------------------------------
   // Timing (cycles at 200 MHz, 5 ns)
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 5;
   localparam int STROBE_NS      = 70;
   localparam int STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_NS        = 30;
   localparam int TURN_CYC       = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W          = 8;
   // ----------------------------------------------------------------
   // Host commands
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FSH_OP_FLASH_READ,
      FSH_OP_FLASH_WRITE,
      FSH_OP_SRAM_READ,
      FSH_OP_SRAM_WRITE,
      FSH_OP_SOFT_RESET,
      FSH_OP_HARD_RESET,
      FSH_OP_POLL,
      FSH_OP_PROT_CHECK
   } fsh_op_t;
endpackage

// >>> core/fsh_host.sv
`timescale 1ns/1ps
// Function
// - Host resets flash before first command sequence
// - Write strobe high throughout read cycles
// - Host never drives while memory drives
// - Poll at program, block or outside address
// - Protection read uses A6,A1,A0 = 0,1,0
module fsh_host (
   input  wire logic                       i_mclk,
   input  wire logic                       i_rst_n,
   input  wire logic                       i_req_valid,
   input  wire fsh_pkg::fsh_op_t           i_req_op,
   input  wire logic [fsh_pkg::ADDR_W-1:0] i_req_addr,
   input  wire logic [fsh_pkg::DATA_W-1:0] i_req_wdata,
   output logic                            o_req_ready,
   output logic                            o_rsp_valid,
   output logic [fsh_pkg::DATA_W-1:0]      o_rsp_rdata,
   output logic                            o_rsp_busy,
   output logic                            o_rsp_protected,
   output logic [fsh_pkg::ADDR_W-1:0]      o_addr,
   output logic [fsh_pkg::DATA_W-1:0]      o_dq_out,
   output logic                            o_dq_oe,
   input  wire logic [fsh_pkg::DATA_W-1:0] i_dq_in,
   output logic                            o_flash_select_n,
   output logic                            o_sram_select_first_n,
   output logic                            o_sram_select_second,
   output logic                            o_upper_byte_select_n,
   output logic                            o_lower_byte_select_n,
   output logic                            o_oe_n,
   output logic                            o_we_n,
   output logic                            o_flash_reset_n,
   input  wire logic                       i_ready_busy_out
);
   typedef enum logic [3:0] {
      ST_INIT, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_TURN, ST_RESP, ST_HRST
   } fsh_state_t;

   fsh_state_t                  state;
   logic [fsh_pkg::CNT_W-1:0]   cnt;
   logic [2:0]                  seq_idx;
   logic [2:0]                  seq_len;
   logic                        is_write;
   logic                        is_flash;
   logic                        is_poll;
   logic                        is_prot;
   logic                        poll_second;
   logic [fsh_pkg::DATA_W-1:0]  poll_first;
   logic [fsh_pkg::ADDR_W-1:0]  cyc_addr;
   logic [fsh_pkg::DATA_W-1:0]  cyc_data;
   logic [fsh_pkg::ADDR_W-1:0]  req_addr;
   logic [fsh_pkg::DATA_W-1:0]  req_wdata;
   logic [fsh_pkg::ADDR_W-1:0]  next_addr;
   logic [fsh_pkg::DATA_W-1:0]  next_data;
   logic                        next_write;

   // ----------------------------------------------------------------
   // Bus cycle selection within a sequence
   // ----------------------------------------------------------------
   always_comb begin
      next_addr  = req_addr;
      next_data  = req_wdata;
      next_write = is_write;
      if (is_prot || (is_write && is_flash && seq_len > 3'h1)) begin
         case (seq_idx)
            3'h0: begin
               next_addr  = fsh_pkg::UNLOCK_ADDR1;
               next_data  = fsh_pkg::UNLOCK_DATA1;
               next_write = 1'b1;
            end
            3'h1: begin
               next_addr  = fsh_pkg::UNLOCK_ADDR2;
               next_data  = fsh_pkg::UNLOCK_DATA2;
               next_write = 1'b1;
            end
            3'h2: begin
               next_addr  = fsh_pkg::UNLOCK_ADDR1;
               next_data  = is_prot ? fsh_pkg::CMD_ID_READ : fsh_pkg::CMD_SOFT_RESET;
               next_write = 1'b1;
            end
            default: begin
               next_addr      = req_addr;
               next_addr[6]   = fsh_pkg::PROT_ID_PATTERN[2];
               next_addr[1]   = fsh_pkg::PROT_ID_PATTERN[1];
               next_addr[0]   = fsh_pkg::PROT_ID_PATTERN[0];
               next_write     = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state       <= ST_INIT;
         cnt         <= '0;
         seq_idx     <= 3'h0;
         seq_len     <= 3'h0;
         is_write    <= 1'b0;
         is_flash    <= 1'b0;
         is_poll     <= 1'b0;
         is_prot     <= 1'b0;
         poll_second <= 1'b0;
         req_addr    <= '0;
         req_wdata   <= '0;
         cyc_addr    <= '0;
         cyc_data    <= '0;
      end else begin
         case (state)
            ST_INIT: begin
               cnt   <= '0;
               state <= ST_HRST;
            end
            ST_HRST: begin
               cnt <= cnt + fsh_pkg::CNT_W'(1);
               if (cnt == fsh_pkg::CNT_W'(fsh_pkg::RESET_PULSE_CYC)) begin
                  cnt   <= '0;
                  state <= ST_TURN;
               end
            end
            ST_IDLE: begin
               if (i_req_valid) begin
                  req_addr    <= i_req_addr;
                  req_wdata   <= i_req_wdata;
                  seq_idx     <= 3'h0;
                  poll_second <= 1'b0;
                  is_poll     <= (i_req_op == fsh_pkg::FSH_OP_POLL);
                  is_prot     <= (i_req_op == fsh_pkg::FSH_OP_PROT_CHECK);
                  is_flash    <= (i_req_op != fsh_pkg::FSH_OP_SRAM_READ) &&
                                 (i_req_op != fsh_pkg::FSH_OP_SRAM_WRITE);
                  is_write    <= (i_req_op == fsh_pkg::FSH_OP_FLASH_WRITE) ||
                                 (i_req_op == fsh_pkg::FSH_OP_SRAM_WRITE) ||
                                 (i_req_op == fsh_pkg::FSH_OP_SOFT_RESET);
                  seq_len     <= (i_req_op == fsh_pkg::FSH_OP_PROT_CHECK) ? 3'h4 :
                                 (i_req_op == fsh_pkg::FSH_OP_SOFT_RESET) ? 3'h3 : 3'h1;
                  cnt         <= '0;
                  state       <= (i_req_op == fsh_pkg::FSH_OP_HARD_RESET) ? ST_HRST : ST_SETUP;
               end
            end
            ST_SETUP: begin
               cyc_addr <= next_addr;
               cyc_data <= next_data;
               is_write <= next_write;
               state    <= ST_STROBE;
            end
            ST_STROBE: begin
               cnt <= cnt + fsh_pkg::CNT_W'(1);
               if (cnt == fsh_pkg::CNT_W'(fsh_pkg::STROBE_CYC)) begin
                  cnt   <= '0;
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (is_poll && !poll_second) begin
                  poll_second <= 1'b1;
                  state       <= ST_TURN;
               end else if (seq_idx + 3'h1 < seq_len) begin
                  seq_idx <= seq_idx + 3'h1;
                  state   <= ST_TURN;
               end else begin
                  state <= ST_RESP;
               end
            end
            ST_TURN: begin
               cnt <= cnt + fsh_pkg::CNT_W'(1);
               if (cnt == fsh_pkg::CNT_W'(fsh_pkg::TURN_CYC)) begin
                  cnt   <= '0;
                  state <= (seq_len == 3'h0) ? ST_IDLE :
                           (poll_second || seq_idx != 3'h0) ? ST_SETUP : ST_IDLE;
                  if (seq_len == 3'h0) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_RESP: begin
               seq_len <= 3'h0;
               state   <= ST_IDLE;
            end
            default: state <= ST_INIT;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_addr                <= '0;
         o_dq_out              <= '0;
         o_dq_oe               <= 1'b0;
         o_flash_select_n      <= 1'b1;
         o_sram_select_first_n <= 1'b1;
         o_sram_select_second  <= 1'b0;
         o_upper_byte_select_n <= 1'b1;
         o_lower_byte_select_n <= 1'b1;
         o_oe_n                <= 1'b1;
         o_we_n                <= 1'b1;
         o_flash_reset_n       <= 1'b0;
      end else begin
         o_flash_reset_n <= (state != ST_HRST) && (state != ST_INIT);
         o_addr          <= cyc_addr;
         o_dq_out        <= cyc_data;
         o_flash_select_n      <= !((state == ST_STROBE) && is_flash);
         o_sram_select_first_n <= !((state == ST_STROBE) && !is_flash);
         o_sram_select_second  <= (state == ST_STROBE) && !is_flash;
         o_upper_byte_select_n <= !((state == ST_STROBE) && !is_flash);
         o_lower_byte_select_n <= !((state == ST_STROBE) && !is_flash);
         o_we_n  <= !((state == ST_STROBE) && is_write);
         o_oe_n  <= !((state == ST_STROBE) && !is_write);
         o_dq_oe <= (state == ST_STROBE) && is_write;
      end
   end

   // ----------------------------------------------------------------
   // Read capture and answer
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         poll_first      <= '0;
         o_rsp_valid     <= 1'b0;
         o_rsp_rdata     <= '0;
         o_rsp_busy      <= 1'b0;
         o_rsp_protected <= 1'b0;
         o_req_ready     <= 1'b0;
      end else begin
         o_req_ready <= (state == ST_IDLE) && !i_req_valid;
         o_rsp_valid <= (state == ST_RESP);
         if (state == ST_STROBE && !is_write &&
             cnt == fsh_pkg::CNT_W'(fsh_pkg::STROBE_CYC)) begin
            if (is_poll && !poll_second) begin
               poll_first <= i_dq_in;
            end else begin
               o_rsp_rdata <= i_dq_in;
               o_rsp_busy  <= is_poll &&
                  ((poll_first[fsh_pkg::MAIN_TOGGLE_BIT] != i_dq_in[fsh_pkg::MAIN_TOGGLE_BIT]) ||
                   !i_ready_busy_out);
               o_rsp_protected <= is_prot && (i_dq_in == fsh_pkg::PROT_YES);
            end
         end
      end
   end
endmodule

// >>> verification/fsh_dev_model.sv
`timescale 1ns/1ps
module fsh_dev_model #(
   parameter logic [5:0] PROT_BLK = 6'h05
) (
   input  wire logic [21:0] i_addr,
   input  wire logic [15:0] i_host_dq,
   input  wire logic        i_host_oe,
   input  wire logic        i_flash_select_n,
   input  wire logic        i_sram_select_first_n,
   input  wire logic        i_sram_select_second,
   input  wire logic        i_byte_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic        i_reset_n,
   output wire logic [15:0] o_bus,
   output wire logic        o_ready_busy_out
);
   // ----------------
   // Device state
   // ----------------
   logic [15:0] sram [0:255];
   logic [15:0] rd, last_val, cmd_d;
   logic [21:0] cmd_a, last_addr;
   logic [1:0]  step;
   logic        pend, id_mode, tog, show_tog, skip;
   int          busy_left, hw_resets, sw_resets;
   wire         f_rd = !i_flash_select_n && !i_oe_n && i_we_n;
   wire         s_on = !i_sram_select_first_n && i_sram_select_second && !i_byte_n;
   wire         s_rd = s_on && !i_oe_n && i_we_n;
   initial begin
      {step, pend, id_mode, tog, show_tog, last_val} = '0;
      {busy_left, hw_resets, sw_resets} = '0;
      skip = (i_we_n | i_flash_select_n | i_oe_n) === 1'b0;
   end
   always @(posedge i_reset_n) begin
      hw_resets++;
      step = 2'd0;
      id_mode = 1'b0;
   end
   always @* if (!i_flash_select_n && !i_we_n) begin
      cmd_a = i_addr;
      cmd_d = i_host_dq;
      pend = 1'b1;
   end
   always @(posedge i_we_n or posedge i_flash_select_n) if (pend) begin
      pend = 1'b0;
      if (skip) skip = 1'b0;
      else if (cmd_d[7:0] == 8'hf0) begin
         step = 2'd0;
         id_mode = 1'b0;
         sw_resets++;
      end else if (step == 2'd0 && cmd_a[10:0] == 11'h555 && cmd_d[7:0] == 8'haa) step = 2'd1;
      else if (step == 2'd1 && cmd_a[10:0] == 11'h2aa && cmd_d[7:0] == 8'h55) step = 2'd2;
      else begin
         id_mode = id_mode || (step == 2'd2 && cmd_d[7:0] == 8'h90);
         step = 2'd0;
      end
   end
   always @(negedge i_oe_n) begin
      last_addr = i_addr;
      show_tog = !i_flash_select_n && busy_left > 0;
      if (show_tog) begin
         tog = ~tog;
         busy_left--;
      end
   end
   always_comb begin
      rd = i_addr[15:0] ^ 16'h3c3c;
      if (show_tog) rd[6] = tog;
      if (id_mode) rd = {15'h0000, {i_addr[6], i_addr[1:0]} == 3'b010
                                   && i_addr[21:16] == PROT_BLK};
      if (s_rd) rd = sram[i_addr[7:0]];
   end
   always @* if (s_on && !i_we_n) sram[i_addr[7:0]] = i_host_dq;
   always @* if (f_rd || s_rd) last_val = rd;
   // Released bus shows the inverse of the last value the memory drove
   assign o_bus = i_host_oe ? i_host_dq : (f_rd || s_rd) ? rd : ~last_val;
   assign o_ready_busy_out = (busy_left == 0);
endmodule

// >>> verification/fsh_host_sva.sv
`timescale 1ns/1ps
module fsh_host_sva (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic o_req_ready,
   input wire logic o_dq_oe,
   input wire logic o_flash_select_n,
   input wire logic o_sram_select_first_n,
   input wire logic o_sram_select_second,
   input wire logic o_oe_n,
   input wire logic o_we_n,
   input wire logic o_flash_reset_n
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // ----------------
   // Bus strobes
   // ----------------
   sequence s_rd_strobe;
      (!o_oe_n && o_we_n) [*8];
   endsequence
   sequence s_wr_strobe;
      (!o_we_n && o_oe_n) [*8];
   endsequence
   chk_we_read_high: assert property (!o_oe_n |-> o_we_n)
      else $error("write strobe low in read");
   chk_read_steady: assert property ($fell(o_oe_n) |-> s_rd_strobe)
      else $error("read strobe disturbed");
   chk_write_quiet: assert property ($fell(o_we_n) |-> s_wr_strobe)
      else $error("output enable low in write");
   chk_no_drive_read: assert property (!o_oe_n |-> !o_dq_oe)
      else $error("host drives data in read");
   chk_turn_quiet: assert property ($rose(o_oe_n) |-> !o_dq_oe [*2])
      else $error("host drives data right after read");
   chk_one_memory: assert property (!o_flash_select_n |->
      (o_sram_select_first_n || !o_sram_select_second)) else $error("both memories selected");
   chk_reset_pulse: assert property ($rose(i_rst_n) |-> !o_flash_reset_n [*8])
      else $error("flash reset pulse missing");
   chk_reset_first: assert property (!o_flash_reset_n |->
      o_flash_select_n && !o_req_ready) else $error("activity during flash reset");
endmodule
bind fsh_host fsh_host_sva chk_u (.i_mclk, .i_rst_n, .o_req_ready, .o_dq_oe, .o_flash_select_n,
   .o_sram_select_first_n, .o_sram_select_second, .o_oe_n, .o_we_n, .o_flash_reset_n);

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
   logic             i_mclk = 1'b0;
   logic             i_rst_n = 1'b0;
   logic             i_req_valid = 1'b0;
   fsh_pkg::fsh_op_t i_req_op = fsh_pkg::FSH_OP_FLASH_READ;
   logic [21:0]      i_req_addr = '0;
   logic [15:0]      i_req_wdata = '0;
   logic [15:0]      o_rsp_rdata, o_dq_out, i_dq_in;
   logic [21:0]      o_addr;
   logic             o_req_ready, o_rsp_valid, o_rsp_busy, o_rsp_protected, o_dq_oe;
   logic             o_flash_select_n, o_sram_select_first_n, o_sram_select_second, o_oe_n;
   logic             o_upper_byte_select_n, o_lower_byte_select_n, o_we_n, o_flash_reset_n;
   logic             i_ready_busy_out;
   int               bad_count = 0;
   int               total_checks = 0;
   always #2.5 i_mclk = ~i_mclk;
   fsh_host dut_u (.i_mclk, .i_rst_n, .i_req_valid, .i_req_op, .i_req_addr, .i_req_wdata,
      .o_req_ready, .o_rsp_valid, .o_rsp_rdata, .o_rsp_busy, .o_rsp_protected, .o_addr,
      .o_dq_out, .o_dq_oe, .i_dq_in, .o_flash_select_n, .o_sram_select_first_n,
      .o_sram_select_second, .o_upper_byte_select_n, .o_lower_byte_select_n, .o_oe_n,
      .o_we_n, .o_flash_reset_n, .i_ready_busy_out);
   fsh_dev_model dev_u (.i_addr(o_addr), .i_host_dq(o_dq_out), .i_host_oe(o_dq_oe),
      .i_flash_select_n(o_flash_select_n), .i_sram_select_first_n(o_sram_select_first_n),
      .i_sram_select_second(o_sram_select_second),
      .i_byte_n(o_upper_byte_select_n | o_lower_byte_select_n), .i_oe_n(o_oe_n),
      .i_we_n(o_we_n), .i_reset_n(o_flash_reset_n), .o_bus(i_dq_in),
      .o_ready_busy_out(i_ready_busy_out));
   // ----------------
   // Helpers
   // ----------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_for(input bit rsp);
      for (int n = 0; (rsp ? o_rsp_valid : o_req_ready) !== 1'b1; n++) begin
         @(negedge i_mclk);
         if (n > 3000) begin
            check("timeout", 32'h1, 32'h0);
            summarize();
         end
      end
   endtask
   task automatic do_req(input fsh_pkg::fsh_op_t op, input logic [21:0] a);
      wait_for(1'b0);
      i_req_valid = 1'b1;
      i_req_op = op;
      i_req_addr = a;
      i_req_wdata = 16'hbe00 + 16'(a[0]);
      @(negedge i_mclk);
      i_req_valid = 1'b0;
      if (op == fsh_pkg::FSH_OP_HARD_RESET) repeat (4) @(negedge i_mclk);
      wait_for(op != fsh_pkg::FSH_OP_HARD_RESET);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_flash();
      wait_for(1'b0);
      check("hw_resets", dev_u.hw_resets, 1);
      for (int i = 0; i < 2; i++) begin
         do_req(fsh_pkg::FSH_OP_FLASH_READ, i ? 22'h3fffff : 22'h000123);
         check("flash_rd", o_rsp_rdata, (i ? 16'hffff : 16'h0123) ^ 16'h3c3c);
      end
   endtask
   task automatic t_sram();
      for (int i = 0; i < 2; i++) do_req(fsh_pkg::FSH_OP_SRAM_WRITE, 22'h000010 + 22'(i));
      for (int i = 0; i < 2; i++) begin
         do_req(fsh_pkg::FSH_OP_SRAM_READ, 22'h000010 + 22'(i));
         check("sram_rd", o_rsp_rdata, 16'hbe00 + 16'(i));
      end
   endtask
   task automatic t_flash_write();
      do_req(fsh_pkg::FSH_OP_FLASH_WRITE, 22'h000013);
      check("wr_addr", dev_u.cmd_a, 22'h000013);
      check("wr_data", dev_u.cmd_d, 16'hbe01);
   endtask
   task automatic t_poll();
      dev_u.busy_left = 4;
      for (int i = 0; i < 3; i++) begin
         do_req(fsh_pkg::FSH_OP_POLL, 22'h012345);
         check("poll_busy", o_rsp_busy, i < 2);
         check("poll_addr", dev_u.last_addr, 22'h012345);
      end
      check("poll_data", o_rsp_rdata, 16'h2345 ^ 16'h3c3c);
   endtask
   task automatic t_prot();
      for (int i = 0; i < 2; i++) begin
         do_req(fsh_pkg::FSH_OP_PROT_CHECK, {i ? 6'h09 : 6'h05, 16'h0000});
         check("prot_flag", o_rsp_protected, i == 0);
         check("prot_data", o_rsp_rdata, i ? 16'h0000 : 16'h0001);
         check("prot_low", {dev_u.last_addr[6], dev_u.last_addr[1:0]}, 3'b010);
         check("prot_blk", dev_u.last_addr[21:16], i ? 6'h09 : 6'h05);
      end
   endtask
   task automatic t_resets();
      int n0;
      n0 = dev_u.sw_resets;
      do_req(fsh_pkg::FSH_OP_SOFT_RESET, 22'h000000);
      check("sw_resets", dev_u.sw_resets, n0 + 1);
      do_req(fsh_pkg::FSH_OP_FLASH_READ, 22'h000200);
      check("read_mode", o_rsp_rdata, 16'h0200 ^ 16'h3c3c);
      n0 = dev_u.hw_resets;
      do_req(fsh_pkg::FSH_OP_HARD_RESET, 22'h000000);
      check("hw_pulse", dev_u.hw_resets, n0 + 1);
   endtask
   initial begin
      repeat (12) @(negedge i_mclk);
      i_rst_n = 1'b1;
      t_flash();
      t_sram();
      t_flash_write();
      t_poll();
      t_prot();
      t_resets();
      summarize();
   end
endmodule
